// ### design/srw_supervisor.sv
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - reset low while supply invalid
// - hold reset 50 or 200 ms after recovery
// - active-high reset is complement of low
// - no kick within timeout gives reset pulse
// - fixed variant uses 1.6 s timeout only
// - fixed variant pulses are 50 ms
// - internal osc; input level picks timeout
// - long timeout right after any reset
// - watchdog restarts at end of reset
// - first kick after reset selects normal timeout
// - both kick edges restart the count
// - steady kick resets every long timeout
// - floating kick disables the watchdog
// - external clock: 1024 and 4096 clocks
// - external clock pulses 512 or 2048 clocks
// - internal timing from 10.24 kHz oscillator
// - expired flag low until next kick
// - expired flag high when supply fails
// - expired flag high while watchdog disabled
module srw_supervisor #(
  parameter bit FIXED_TIMING = 1'b0,
  parameter bit LONG_PULSE = 1'b0,
  parameter int unsigned OSC_DIV = srw_pkg::OSC_DIV_CYCLES
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // supply monitor
  input wire logic supply_valid,
  // watchdog kick, already decoded from three levels
  input wire logic wdog_kick_in,
  input wire logic wdog_kick_float,
  // oscillator selection
  input wire logic osc_source_select,
  input wire logic osc_input_pin,
  // resets toward the processor
  output var logic reset_out_n,
  output var logic reset_out,
  // watchdog status
  output var logic wdog_expired_n,
  output var logic wdog_long_active
);

  // ****************************************
  // decode helpers
  // ****************************************
  function automatic logic [srw_pkg::CNT_W-1:0] wd_limit(
    input logic fixed,
    input logic ext,
    input logic osc_level,
    input logic after_rst
  );
    logic [srw_pkg::CNT_W-1:0] lim;
    lim = srw_pkg::WD_LONG_TICKS;
    if (fixed) begin
      lim = srw_pkg::WD_LONG_TICKS;
    end else if (ext) begin
      lim = after_rst ? srw_pkg::EXT_WD_AFTER_RST_OSCILLATOR_CYCLES
                      : srw_pkg::EXT_WD_NORMAL_OSCILLATOR_CYCLES;
    end else if (after_rst || osc_level) begin
      lim = srw_pkg::WD_LONG_TICKS;
    end else begin
      lim = srw_pkg::WD_SHORT_TICKS;
    end
    return lim;
  endfunction

  function automatic logic [srw_pkg::CNT_W-1:0] pulse_limit(
    input logic fixed,
    input logic ext,
    input logic long_pulse
  );
    logic [srw_pkg::CNT_W-1:0] lim;
    lim = srw_pkg::PULSE_SHORT_TICKS;
    if (fixed) begin
      lim = srw_pkg::PULSE_SHORT_TICKS;
    end else if (ext) begin
      lim = long_pulse ? srw_pkg::EXT_PULSE_LONG_OSCILLATOR_CYCLES
                       : srw_pkg::EXT_PULSE_SHORT_OSCILLATOR_CYCLES;
    end else begin
      lim = long_pulse ? srw_pkg::PULSE_LONG_TICKS
                       : srw_pkg::PULSE_SHORT_TICKS;
    end
    return lim;
  endfunction

  // ****************************************
  // declarations
  // ****************************************
  srw_tick_if tick_bus ();

  logic sup_s1_ff, sup_s2_ff;
  logic kick_s1_ff, kick_s2_ff, kick_prev_ff;
  logic flt_s1_ff, flt_s2_ff;
  logic kick_edge;
  logic wd_enabled;

  srw_pkg::srw_state_t state_ff, nxt_state;
  logic [srw_pkg::CNT_W-1:0] pulse_cnt_ff, nxt_pulse_cnt;
  logic [srw_pkg::CNT_W-1:0] wd_cnt_ff, nxt_wd_cnt;
  logic [srw_pkg::CNT_W-1:0] wd_lim, pls_lim;
  logic after_rst_ff;
  logic pulse_done;
  logic wd_timeout;
  logic pulse_restart;

  // ****************************************
  // time base
  // ****************************************
  srw_timebase #(
    .DIV(OSC_DIV)
  ) u_timebase (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .osc_source_select(osc_source_select),
    .osc_input_pin(osc_input_pin),
    .tb(tick_bus.src)
  );

  // ****************************************
  // input synchronisers
  // ****************************************
  // reset values assume an invalid supply and an idle, disabled kick
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sup_s1_ff <= 1'b0;
      sup_s2_ff <= 1'b0;
    end else begin
      sup_s1_ff <= supply_valid;
      sup_s2_ff <= sup_s1_ff;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      kick_s1_ff <= 1'b0;
      kick_s2_ff <= 1'b0;
      kick_prev_ff <= 1'b0;
      flt_s1_ff <= 1'b1;
      flt_s2_ff <= 1'b1;
    end else begin
      kick_s1_ff <= wdog_kick_in;
      kick_s2_ff <= kick_s1_ff;
      kick_prev_ff <= kick_s2_ff;
      flt_s1_ff <= wdog_kick_float;
      flt_s2_ff <= flt_s1_ff;
    end
  end

  // a kick that toggles while floating carries no meaning
  assign wd_enabled = ~flt_s2_ff;
  assign kick_edge = wd_enabled & (kick_s2_ff ^ kick_prev_ff);

  // ****************************************
  // limits
  // ****************************************
  assign wd_lim = wd_limit(FIXED_TIMING, tick_bus.ext_mode, tick_bus.osc_level, after_rst_ff);
  assign pls_lim = pulse_limit(FIXED_TIMING, tick_bus.ext_mode, LONG_PULSE);
  assign pulse_done = tick_bus.tick && ((pulse_cnt_ff + srw_pkg::CNT_ONE) >= pls_lim);
  // a kick in the expiry cycle restarts the count and wins
  assign wd_timeout = (state_ff == srw_pkg::SRW_RUN) && wd_enabled && !kick_edge &&
                      tick_bus.tick && ((wd_cnt_ff + srw_pkg::CNT_ONE) >= wd_lim);
  assign pulse_restart = (state_ff == srw_pkg::SRW_SUPPLY_LOW) && sup_s2_ff;

  // ****************************************
  // reset sequencer
  // ****************************************
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      srw_pkg::SRW_SUPPLY_LOW: begin
        if (sup_s2_ff) begin
          nxt_state = srw_pkg::SRW_PULSE;
        end
      end
      srw_pkg::SRW_PULSE: begin
        if (!sup_s2_ff) begin
          nxt_state = srw_pkg::SRW_SUPPLY_LOW;
        end else if (pulse_done) begin
          nxt_state = srw_pkg::SRW_RUN;
        end
      end
      srw_pkg::SRW_RUN: begin
        if (!sup_s2_ff) begin
          nxt_state = srw_pkg::SRW_SUPPLY_LOW;
        end else if (wd_timeout) begin
          nxt_state = srw_pkg::SRW_PULSE;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= srw_pkg::SRW_SUPPLY_LOW;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ****************************************
  // pulse width counter
  // ****************************************
  always_comb begin
    nxt_pulse_cnt = pulse_cnt_ff;
    if (state_ff != srw_pkg::SRW_PULSE || pulse_restart) begin
      nxt_pulse_cnt = srw_pkg::CNT_ZERO;
    end else if (tick_bus.tick && !pulse_done) begin
      nxt_pulse_cnt = pulse_cnt_ff + srw_pkg::CNT_ONE;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pulse_cnt_ff <= srw_pkg::CNT_ZERO;
    end else begin
      pulse_cnt_ff <= nxt_pulse_cnt;
    end
  end

  // ****************************************
  // watchdog counter
  // ****************************************
  // held at zero outside run, so every reset ends with a fresh count
  always_comb begin
    nxt_wd_cnt = wd_cnt_ff;
    if (state_ff != srw_pkg::SRW_RUN || !wd_enabled) begin
      nxt_wd_cnt = srw_pkg::CNT_ZERO;
    end else if (kick_edge || wd_timeout) begin
      nxt_wd_cnt = srw_pkg::CNT_ZERO;
    end else if (tick_bus.tick) begin
      nxt_wd_cnt = wd_cnt_ff + srw_pkg::CNT_ONE;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wd_cnt_ff <= srw_pkg::CNT_ZERO;
    end else begin
      wd_cnt_ff <= nxt_wd_cnt;
    end
  end

  // ****************************************
  // post-reset long timeout
  // ****************************************
  // kicks during reset are ignored; only one after release counts
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      after_rst_ff <= 1'b1;
    end else if (state_ff != srw_pkg::SRW_RUN) begin
      after_rst_ff <= 1'b1;
    end else if (kick_edge) begin
      after_rst_ff <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wdog_long_active <= 1'b1;
    end else begin
      wdog_long_active <= (nxt_state != srw_pkg::SRW_RUN) ||
                          (after_rst_ff && !(state_ff == srw_pkg::SRW_RUN && kick_edge));
    end
  end

  // ****************************************
  // reset outputs
  // ****************************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reset_out_n <= 1'b0;
    end else begin
      reset_out_n <= (nxt_state == srw_pkg::SRW_RUN);
    end
  end

  // separate flop rather than an inverter keeps the output registered
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reset_out <= 1'b1;
    end else begin
      reset_out <= (nxt_state != srw_pkg::SRW_RUN);
    end
  end

  // ****************************************
  // watchdog status
  // ****************************************
  // timeout beats the release only if both land together, which the
  // kick gate in wd_timeout makes impossible
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wdog_expired_n <= 1'b1;
    end else if (!sup_s2_ff) begin
      wdog_expired_n <= 1'b1;
    end else if (!wd_enabled) begin
      wdog_expired_n <= 1'b1;
    end else if (wd_timeout) begin
      wdog_expired_n <= 1'b0;
    end else if (kick_edge) begin
      wdog_expired_n <= 1'b1;
    end
  end

endmodule
`default_nettype wire

// ### design/srw_timebase.sv
`timescale 1ns/1ps
`default_nettype none
module srw_timebase #(
  parameter int unsigned DIV = srw_pkg::OSC_DIV_CYCLES
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // oscillator pins, already decoded
  input wire logic osc_source_select,
  input wire logic osc_input_pin,
  // to the supervisor
  srw_tick_if.src tb
);

  localparam logic [srw_pkg::DIV_W-1:0] DIV_LAST = srw_pkg::DIV_W'(DIV - 1);

  logic sel_s1_ff, sel_s2_ff;
  logic pin_s1_ff, pin_s2_ff, pin_prev_ff;
  logic [srw_pkg::DIV_W-1:0] div_cnt_ff;
  logic tick_ff;

  // ****************************************
  // pin synchronisers
  // ****************************************
  // floating pins are decoded high, so reset to high
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_s1_ff <= 1'b1;
      sel_s2_ff <= 1'b1;
      pin_s1_ff <= 1'b1;
      pin_s2_ff <= 1'b1;
      pin_prev_ff <= 1'b1;
    end else begin
      sel_s1_ff <= osc_source_select;
      sel_s2_ff <= sel_s1_ff;
      pin_s1_ff <= osc_input_pin;
      pin_s2_ff <= pin_s1_ff;
      pin_prev_ff <= pin_s2_ff;
    end
  end

  // ****************************************
  // internal oscillator divider
  // ****************************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt_ff <= '0;
    end else if (div_cnt_ff == DIV_LAST) begin
      div_cnt_ff <= '0;
    end else begin
      div_cnt_ff <= div_cnt_ff + 1'b1;
    end
  end

  // ext clock must stay below half ref_clk/2 to be seen edge by edge
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_ff <= 1'b0;
    end else if (!sel_s2_ff) begin
      tick_ff <= pin_s2_ff & ~pin_prev_ff;
    end else begin
      tick_ff <= (div_cnt_ff == DIV_LAST);
    end
  end

  assign tb.tick = tick_ff;
  assign tb.ext_mode = ~sel_s2_ff;
  assign tb.osc_level = pin_s2_ff;

endmodule
`default_nettype wire

// ### dv/srw_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module srw_host_model (
  // clock
  input wire logic ref_clk,
  // bench commands
  input wire logic kick_req,
  input wire logic ext_clk_en,
  // toward the supervisor
  output var logic wdog_kick_in,
  output var logic osc_clk
);
  int div_cnt = 0;
  logic kick_lvl = 1'b0;
  logic clk_lvl = 1'b0;
  assign wdog_kick_in = kick_lvl;
  assign osc_clk = clk_lvl;
  // kick stays at its idle level until the host asks
  always @(posedge ref_clk) begin
    if (kick_req) begin
      kick_lvl <= !kick_lvl;
    end
  end
  // clock of 5 ref cycles, below ref_clk/4; stands still when off
  always @(posedge ref_clk) begin
    div_cnt <= (!ext_clk_en || div_cnt == 4) ? 0 : div_cnt + 1;
    clk_lvl <= ext_clk_en && div_cnt < 2;
  end
endmodule
`default_nettype wire

// ### dv/srw_supervisor_bench.sv
`timescale 1ns/1ps
`default_nettype none
module srw_supervisor_bench;
  localparam int OSC_DIV = 2;
  localparam int EXT_DIV = 5;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic supply_valid = 1'b0;
  logic wdog_kick_float = 1'b0;
  logic osc_source_select = 1'b1;
  logic osc_lvl = 1'b0;
  logic kick_req = 1'b0;
  logic ext_clk_en = 1'b0;
  logic wdog_kick_in, osc_clk, osc_pin;
  logic reset_out_n, reset_out, wdog_expired_n, wdog_long_active;
  int error_cnt = 0;
  int comparisons = 0;
  int n;
  int m;
  logic long_rst_n, fixed_rst_n;

  always #5 ref_clk = !ref_clk;
  assign osc_pin = ext_clk_en ? osc_clk : osc_lvl;

  srw_host_model u_host (.ref_clk(ref_clk), .kick_req(kick_req), .ext_clk_en(ext_clk_en),
    .wdog_kick_in(wdog_kick_in), .osc_clk(osc_clk));
  srw_supervisor #(.OSC_DIV(OSC_DIV)) u_dut (.ref_clk(ref_clk), .rst_n(rst_n),
    .supply_valid(supply_valid), .wdog_kick_in(wdog_kick_in),
    .wdog_kick_float(wdog_kick_float), .osc_source_select(osc_source_select),
    .osc_input_pin(osc_pin), .reset_out_n(reset_out_n), .reset_out(reset_out),
    .wdog_expired_n(wdog_expired_n), .wdog_long_active(wdog_long_active));
  // variants share the stimulus; only their active-low reset outputs are watched
  srw_supervisor #(.OSC_DIV(OSC_DIV), .LONG_PULSE(1'b1)) u_dut_long (.ref_clk(ref_clk),
    .rst_n(rst_n), .supply_valid(supply_valid), .wdog_kick_in(wdog_kick_in),
    .wdog_kick_float(wdog_kick_float), .osc_source_select(osc_source_select),
    .osc_input_pin(osc_pin), .reset_out_n(long_rst_n), .reset_out(),
    .wdog_expired_n(), .wdog_long_active());
  srw_supervisor #(.OSC_DIV(OSC_DIV), .FIXED_TIMING(1'b1)) u_dut_fixed (.ref_clk(ref_clk),
    .rst_n(rst_n), .supply_valid(supply_valid), .wdog_kick_in(wdog_kick_in),
    .wdog_kick_float(wdog_kick_float), .osc_source_select(osc_source_select),
    .osc_input_pin(osc_pin), .reset_out_n(fixed_rst_n), .reset_out(),
    .wdog_expired_n(), .wdog_long_active());

  // ****************************************
  // tasks
  // ****************************************
  task automatic chk_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  // a count is accepted from slack below to 12 cycles above the expected value, for sync and tick phase
  task automatic chk_cnt(input int got, input int exp, input int slack);
    comparisons++;
    if (got < exp - slack || got > exp + 12) begin
      error_cnt++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic wait_rst(input logic val, input int max);
    n = 0;
    while (reset_out_n !== val && n < max) begin
      @(negedge ref_clk);
      n++;
    end
  endtask
  task automatic kick();
    @(posedge ref_clk) kick_req <= 1'b1;
    @(posedge ref_clk) kick_req <= 1'b0;
  endtask
  task automatic summarize();
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ****************************************
  // tests
  // ****************************************
  initial begin
    wait (supply_valid === 1'b1);
    m = 0;
    while (long_rst_n !== 1'b1 && m < 9000) begin
      @(negedge ref_clk);
      m++;
    end
    chk_cnt(m, int'(srw_pkg::PULSE_LONG_TICKS) * OSC_DIV, 4);
  end

  initial begin
    #1_000_000;
    error_cnt++;
    summarize();
  end

  initial begin
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (4) @(negedge ref_clk);
    chk_bit(reset_out_n, 1'b0);
    chk_bit(reset_out, 1'b1);
    chk_bit(wdog_expired_n, 1'b1);
    @(posedge ref_clk) supply_valid <= 1'b1;
    wait_rst(1'b1, 4000);
    chk_cnt(n, int'(srw_pkg::PULSE_SHORT_TICKS) * OSC_DIV, 4);
    chk_bit(fixed_rst_n, 1'b1);
    chk_bit(reset_out, 1'b0);
    chk_bit(wdog_long_active, 1'b1);
    kick();
    repeat (8) @(negedge ref_clk);
    chk_bit(wdog_long_active, 1'b0);
    wait_rst(1'b0, 6000);
    chk_cnt(n + 8, int'(srw_pkg::WD_SHORT_TICKS) * OSC_DIV, 4);
    chk_bit(fixed_rst_n, 1'b1);
    chk_bit(wdog_expired_n, 1'b0);
    wait_rst(1'b1, 4000);
    chk_cnt(n, int'(srw_pkg::PULSE_SHORT_TICKS) * OSC_DIV, 4);
    chk_bit(wdog_long_active, 1'b1);
    chk_bit(wdog_expired_n, 1'b0);
    kick();
    repeat (8) @(negedge ref_clk);
    chk_bit(wdog_expired_n, 1'b1);
    repeat (4) begin
      repeat (1500) @(posedge ref_clk);
      kick();
    end
    @(negedge ref_clk);
    chk_bit(reset_out_n, 1'b1);
    @(posedge ref_clk) wdog_kick_float <= 1'b1;
    repeat (5000) @(negedge ref_clk);
    chk_bit(reset_out_n, 1'b1);
    chk_bit(wdog_expired_n, 1'b1);
    @(posedge ref_clk) wdog_kick_float <= 1'b0;
    kick();
    wait_rst(1'b0, 6000);
    chk_bit(wdog_expired_n, 1'b0);
    @(posedge ref_clk) supply_valid <= 1'b0;
    repeat (5) @(negedge ref_clk);
    chk_bit(wdog_expired_n, 1'b1);
    chk_bit(reset_out_n, 1'b0);
    @(posedge ref_clk);
    osc_source_select <= 1'b0;
    ext_clk_en <= 1'b1;
    supply_valid <= 1'b1;
    wait_rst(1'b1, 4000);
    chk_cnt(n, int'(srw_pkg::EXT_PULSE_SHORT_OSCILLATOR_CYCLES) * EXT_DIV, 2 * EXT_DIV);
    wait_rst(1'b0, 25000);
    chk_cnt(n, int'(srw_pkg::EXT_WD_AFTER_RST_OSCILLATOR_CYCLES) * EXT_DIV, 2 * EXT_DIV);
    wait_rst(1'b1, 4000);
    kick();
    wait_rst(1'b0, 8000);
    chk_cnt(n + 1, int'(srw_pkg::EXT_WD_NORMAL_OSCILLATOR_CYCLES) * EXT_DIV, 2 * EXT_DIV);
    summarize();
  end
endmodule
`default_nettype wire

// ### dv/srw_supervisor_properties.sv
`timescale 1ns/1ps
`default_nettype none
module srw_supervisor_properties (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // inputs
  input wire logic supply_valid,
  input wire logic wdog_kick_in,
  input wire logic wdog_kick_float,
  input wire logic osc_source_select,
  input wire logic osc_input_pin,
  // outputs
  input wire logic reset_out_n,
  input wire logic reset_out,
  input wire logic wdog_expired_n,
  input wire logic wdog_long_active
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_supply_gone;
    !supply_valid [*3];
  endsequence
  sequence s_pulse_end;
    !reset_out_n ##1 reset_out_n;
  endsequence

  a_reset_complement: assert property (reset_out == !reset_out_n)
    else $error("active-high reset is not the complement");
  a_supply_low_reset: assert property (s_supply_gone |=> !reset_out_n)
    else $error("reset not asserted with supply low");
  a_supply_flag_high: assert property (s_supply_gone |=> wdog_expired_n)
    else $error("expired flag low with supply low");
  a_float_flag_high: assert property (wdog_kick_float [*3] |=> wdog_expired_n)
    else $error("expired flag low while watchdog disabled");
  a_long_in_reset: assert property (!reset_out_n && $past(!reset_out_n) |-> wdog_long_active)
    else $error("long timeout not in force during reset");
  a_long_after_pulse: assert property (s_pulse_end |-> wdog_long_active)
    else $error("long timeout not applied at end of reset");
  a_expiry_gives_reset: assert property ($fell(wdog_expired_n) |-> !reset_out_n)
    else $error("expiry without reset pulse");
  a_expired_hold: assert property (
    (!wdog_expired_n && $stable(wdog_kick_in) && supply_valid && !wdog_kick_float) [*6]
    |=> !wdog_expired_n)
    else $error("expired flag rose without a kick");
  a_release_needs_supply: assert property (
    $rose(reset_out_n) |-> $past(supply_valid, 4) && $past(supply_valid, 8))
    else $error("reset released without valid supply");
  a_long_clear_running: assert property ($fell(wdog_long_active) |-> $past(reset_out_n))
    else $error("long timeout cleared while in reset");
endmodule
bind srw_supervisor srw_supervisor_properties u_props (
  .ref_clk(ref_clk), .rst_n(rst_n), .supply_valid(supply_valid),
  .wdog_kick_in(wdog_kick_in), .wdog_kick_float(wdog_kick_float),
  .osc_source_select(osc_source_select), .osc_input_pin(osc_input_pin),
  .reset_out_n(reset_out_n), .reset_out(reset_out),
  .wdog_expired_n(wdog_expired_n), .wdog_long_active(wdog_long_active)
);
`default_nettype wire

// ### inc/srw_pkg.sv
`default_nettype none
package srw_pkg;

  // ****************************************
  // clocking
  // ****************************************
  localparam int unsigned REF_CLK_HZ = 100_000_000;
  localparam int unsigned OSC_FREQ_HZ = 10_240;
  localparam int unsigned MS_PER_S = 1_000;
  localparam int unsigned OSC_DIV_CYCLES = REF_CLK_HZ / OSC_FREQ_HZ;
  localparam int unsigned DIV_W = 14;
  localparam int unsigned CNT_W = 15;

  // ****************************************
  // times in ms, as printed
  // ****************************************
  localparam int unsigned WD_LONG_MS = 1600;
  localparam int unsigned WD_SHORT_MS = 100;
  localparam int unsigned PULSE_SHORT_MS = 50;
  localparam int unsigned PULSE_LONG_MS = 200;

  // ****************************************
  // counts in oscillator_cycles
  // ****************************************
  localparam logic [CNT_W-1:0] WD_LONG_TICKS = CNT_W'(WD_LONG_MS * OSC_FREQ_HZ / MS_PER_S);
  localparam logic [CNT_W-1:0] WD_SHORT_TICKS = CNT_W'(WD_SHORT_MS * OSC_FREQ_HZ / MS_PER_S);
  localparam logic [CNT_W-1:0] PULSE_SHORT_TICKS =
    CNT_W'(PULSE_SHORT_MS * OSC_FREQ_HZ / MS_PER_S);
  localparam logic [CNT_W-1:0] PULSE_LONG_TICKS = CNT_W'(PULSE_LONG_MS * OSC_FREQ_HZ / MS_PER_S);
  localparam logic [CNT_W-1:0] EXT_WD_NORMAL_OSCILLATOR_CYCLES = 15'h0400;
  localparam logic [CNT_W-1:0] EXT_WD_AFTER_RST_OSCILLATOR_CYCLES = 15'h1000;
  localparam logic [CNT_W-1:0] EXT_PULSE_SHORT_OSCILLATOR_CYCLES = 15'h0200;
  localparam logic [CNT_W-1:0] EXT_PULSE_LONG_OSCILLATOR_CYCLES = 15'h0800;
  localparam logic [CNT_W-1:0] CNT_ZERO = 15'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 15'h0001;

  // ****************************************
  // reset sequencer states
  // ****************************************
  typedef enum logic [1:0] {
    SRW_SUPPLY_LOW,
    SRW_PULSE,
    SRW_RUN
  } srw_state_t;

endpackage
`default_nettype wire

// ### inc/srw_tick_if.sv
`timescale 1ns/1ps
`default_nettype none
interface srw_tick_if;
  logic tick;
  logic ext_mode;
  logic osc_level;

  modport src (
    output tick,
    output ext_mode,
    output osc_level
  );

  modport snk (
    input tick,
    input ext_mode,
    input osc_level
  );
endinterface
`default_nettype wire
